// file: dcg_assertions.sv
// port checks for the checksum generator
// assumes one clock and an async active low reset
module dcg_checker
(
	input wire logic	CLK,
	input wire logic	RST_N,
	input wire logic [3:0]	ADDR,
	input wire logic [31:0]	WDATA,
	input wire logic	WR,
	input wire logic	RD,
	input wire logic [31:0]	RDATA,
	input wire logic	DATA_VALID,
	input wire logic [15:0]	DATA_IN,
	input wire logic [31:0]	CHECKSUM,
	input wire logic	MODE_IP
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_mode_select: assert property (WR && ADDR == 4'h0 |=>
		MODE_IP == $past(WDATA[15])) else $error("mode");
	a_ip_seed: assert property (WR && ADDR == 4'h4 && MODE_IP |=>
		CHECKSUM == {16'h0000, $past(WDATA[15:0])}) else $error("seed");
	a_ip_upper: assert property (MODE_IP && $past(MODE_IP, 2) |->
		CHECKSUM[31:16] == 16'h0000) else $error("upper");
	a_read_answer: assert property (RD && ADDR == 4'h4 |=>
		RDATA == $past(CHECKSUM)) else $error("read");
	a_read_idle: assert property (!$past(RD) |->
		RDATA == 32'h0) else $error("idle");
	a_hold_idle: assert property (!WR && !DATA_VALID |=>
		$stable(CHECKSUM)) else $error("hold");
	a_unit_step: assert property (DATA_VALID && !WR && MODE_IP
		&& DATA_IN != 16'h0 && DATA_IN != 16'hFFFF
		|=> CHECKSUM != $past(CHECKSUM)) else $error("step");
	a_unmapped_read: assert property (RD && ADDR == 4'hC |=>
		RDATA == 32'h0) else $error("unmapped");
	c_ip_unit: cover property (DATA_VALID && MODE_IP);
	c_linear_feedback_shifter_unit: cover property (DATA_VALID && !MODE_IP);
	c_acc_read: cover property (RD && ADDR == 4'h4);
endmodule : dcg_checker
bind dcg_top dcg_checker u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DATA_IN(DATA_IN),
	.DATA_VALID(DATA_VALID), .CHECKSUM(CHECKSUM), .MODE_IP(MODE_IP));

// file: dcg_dma_model.sv
// dma source model: one data unit per send call
// assumes send is entered just after a rising clock edge
module dcg_dma_model
(
	input wire logic	clk,
	output logic	valid = 1'b0,
	output logic [15:0]	data = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	// released bus shows the inverse, so stale data cannot pass
	task send(input logic [15:0] w);
		valid <= 1'b1;
		data <= w;
		@(posedge clk);
		valid <= 1'b0;
		data <= ~w;
		@(posedge clk);
	endtask : send
endmodule : dcg_dma_model

// file: dcg_ipsum.sv
// adds one 16-bit word into a ones-complement sum with end-around carry
// assumes the sum is held in true (non-inverted) form
module dcg_ipsum
(
	input  wire logic [15:0] sum_in,
	input  wire logic [15:0] word,
	output logic      [15:0] sum_out
);
	logic [16:0] raw;

	// the carry out folds back into bit zero
	always_comb
	begin
		raw     = {1'b0, sum_in} + {1'b0, word};
		sum_out = raw[15:0] + {15'h0, raw[16]};
	end
endmodule : dcg_ipsum

// file: dcg_linear_feedback_shifter.sv
// one byte through the linear feedback shifter, bitwise, msb first
// assumes polynomial length field holds length minus one
module dcg_linear_feedback_shifter
(
	input  wire logic [31:0] crc_in,
	input  wire logic [31:0] taps,
	input  wire logic [4:0]  polynomial_length,
	input  wire logic [7:0]  data,
	output logic      [31:0] crc_out
);
	// eight shift steps; feedback taken from the top live stage
	always_comb
	begin
		logic [31:0] c;
		logic        fb;
		c  = crc_in;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			fb = c[polynomial_length] ^ data[i];
			c  = {c[30:0], 1'b0};
			for (int s = 0; s < 32; s++)
			begin
				if (taps[s])
				begin
					c[s] = c[s] ^ fb;
				end
				// cleared tap: stage keeps previous stage value
			end
		end
		crc_out = c;
	end
endmodule : dcg_linear_feedback_shifter

// file: dcg_pkg.sv
// package for the dma checksum generator: register offsets, fields, resets
// assumes a 32-bit register port with word offsets and one clock domain
package dcg_pkg;
	localparam logic [3:0]  OFS_CONTROL     = 4'h0;
	localparam logic [3:0]  OFS_ACCUMULATOR = 4'h4;
	localparam logic [3:0]  OFS_TAP_ENABLE  = 4'h8;
	localparam int          TYPE_SEL_BIT    = 15;
	localparam int          POLYNOMIAL_LENGTH_LSB        = 8;
	localparam int          POLYNOMIAL_LENGTH_W          = 5;
	localparam int          UNIT_LSB        = 0;
	localparam int          UNIT_W          = 2;
	localparam logic [31:0] RST_CONTROL     = 32'h0000_0000;
	localparam logic [31:0] RST_ACCUMULATOR = 32'h0000_0000;
	localparam logic [31:0] RST_TAP_ENABLE  = 32'h0000_0000;
	localparam logic [31:0] IP_MASK         = 32'h0000_FFFF;

	// modes of the generator
	typedef enum logic [0:0]
	{
		MODE_LINEAR_FEEDBACK_SHIFTER = 1'b0,
		MODE_IP   = 1'b1
	} dcg_mode_t;
endpackage : dcg_pkg

// file: dcg_top.sv
// dma checksum generator: linear_feedback_shifter crc or ip header checksum over dma bytes
// assumes synchronous register port and a byte/halfword strobe from dma
//
// Local design decisions: the register offsets and the strobed register port.
module dcg_top
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic [3:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic        DATA_VALID,
	input  wire logic [15:0] DATA_IN,
	output logic      [31:0] CHECKSUM,
	output logic             MODE_IP
);
	typedef struct packed
	{
		logic [31:0] ctrl;
		logic [31:0] acc;
		logic [31:0] taps;
		logic [31:0] rdata;
		logic [31:0] result;
		logic        mode_ip;
	} dcg_state_t;

	dcg_state_t st_q;
	dcg_state_t st_d;

	logic [31:0] linear_feedback_shifter_b0;
	logic [31:0] linear_feedback_shifter_b1;
	logic [15:0] ip_sum;
	logic [4:0]  polynomial_length;
	logic [31:0] len_mask;
	dcg_pkg::dcg_mode_t mode;

	// visible view of the accumulator, masked per mode
	function automatic logic [31:0] view(input logic [31:0] acc,
		input logic ip, input logic [31:0] mask);
		if (ip)
		begin
			view = {16'h0000, ~acc[15:0]};
		end
		else
		begin
			view = acc & mask;
		end
	endfunction : view

	assign polynomial_length = st_q.ctrl[dcg_pkg::POLYNOMIAL_LENGTH_LSB +: dcg_pkg::POLYNOMIAL_LENGTH_W];
	assign mode = dcg_pkg::dcg_mode_t'(st_q.ctrl[dcg_pkg::TYPE_SEL_BIT]);
	// mask keeps stages 0..polynomial_length; polynomial_length 31 keeps the full word
	assign len_mask = {32{1'b1}} >> (5'd31 - polynomial_length);

	// a second byte lane for halfword units; unit size field picks lanes
	dcg_linear_feedback_shifter u_lfsr0
	(
		.crc_in  (st_q.acc),
		.taps    (st_q.taps),
		.polynomial_length    (polynomial_length),
		.data    (DATA_IN[15:8]),
		.crc_out (linear_feedback_shifter_b0)
	);

	dcg_linear_feedback_shifter u_lfsr1
	(
		.crc_in  (linear_feedback_shifter_b0),
		.taps    (st_q.taps),
		.polynomial_length    (polynomial_length),
		.data    (DATA_IN[7:0]),
		.crc_out (linear_feedback_shifter_b1)
	);

	// the ip sum never sees the tap register
	dcg_ipsum u_ipsum
	(
		.sum_in  (st_q.acc[15:0]),
		.word    (DATA_IN),
		.sum_out (ip_sum)
	);

	// next state: register writes win over data updates in the same cycle
	always_comb
	begin
		st_d         = st_q;
		if (DATA_VALID)
		begin
			if (mode == dcg_pkg::MODE_IP)
			begin
				st_d.acc = {16'h0000, ip_sum};
			end
			else
			begin
				// byte units stop after the upper lane, halfwords run both
				st_d.acc = (st_q.ctrl[dcg_pkg::UNIT_LSB] ? linear_feedback_shifter_b1 : linear_feedback_shifter_b0)
					& len_mask;
			end
		end
		if (WR)
		begin
			unique case (ADDR)
				dcg_pkg::OFS_CONTROL:     st_d.ctrl = WDATA;
				dcg_pkg::OFS_ACCUMULATOR:
				begin
					if (mode == dcg_pkg::MODE_IP)
					begin
						// stored true form; reads invert it back
						st_d.acc = {16'h0000, ~WDATA[15:0]};
					end
					else
					begin
						st_d.acc = WDATA;
					end
				end
				dcg_pkg::OFS_TAP_ENABLE:  st_d.taps = WDATA;
				default:                  st_d.ctrl = st_q.ctrl;
			endcase
		end
		// read data valid only the cycle after the strobe; no side effect
		st_d.rdata = 32'h0000_0000;
		if (RD)
		begin
			unique case (ADDR)
				dcg_pkg::OFS_CONTROL:     st_d.rdata = st_q.ctrl;
				dcg_pkg::OFS_ACCUMULATOR: st_d.rdata = view(st_q.acc,
					st_q.ctrl[dcg_pkg::TYPE_SEL_BIT], len_mask);
				dcg_pkg::OFS_TAP_ENABLE:  st_d.rdata = st_q.taps;
				default:                  st_d.rdata = 32'h0000_0000;
			endcase
		end
		st_d.result = view(st_d.acc, st_d.ctrl[dcg_pkg::TYPE_SEL_BIT],
			{32{1'b1}} >> (5'd31 - st_d.ctrl[dcg_pkg::POLYNOMIAL_LENGTH_LSB +:
			dcg_pkg::POLYNOMIAL_LENGTH_W]));
		// mode flag taken from the next control so it moves with the view
		st_d.mode_ip = st_d.ctrl[dcg_pkg::TYPE_SEL_BIT];
	end

	// single state register
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			st_q.ctrl    <= dcg_pkg::RST_CONTROL;
			st_q.acc     <= dcg_pkg::RST_ACCUMULATOR;
			st_q.taps    <= dcg_pkg::RST_TAP_ENABLE;
			st_q.rdata   <= 32'h0000_0000;
			st_q.result  <= 32'h0000_0000;
			st_q.mode_ip <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign RDATA    = st_q.rdata;
	assign CHECKSUM = st_q.result;
	assign MODE_IP  = st_q.mode_ip;
endmodule : dcg_top

// file: dma_crc_generator_bench.sv
// bench: register and dma stimulus, queued expected reads
// assumes dcg_top, dcg_checker and dcg_dma_model are compiled
module dma_crc_generator_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, dv, pend = 1'b0;
	logic [3:0] addr = 4'h0, pa = 4'h0;
	logic [31:0] csum;
	logic [4:0] p;
	logic [15:0] din;
	logic [16:0] s;
	logic [31:0] wdata = 32'h0, rdata, acc, taps, r = 32'h4D4D1104;
	logic [31:0] exp_q[$];
	int n_fail = 0, checks = 0;
	dcg_top u_dcg_top (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .DATA_VALID(dv), .DATA_IN(din),
		.CHECKSUM(csum), .MODE_IP());
	dcg_dma_model u_dcg_dma_model (.clk(clk), .valid(dv), .data(din));
	initial forever #2 clk = ~clk;
	function automatic logic [31:0] nxt(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nxt
	// msb first; upper bits are masked once at the end, they never feed back
	function automatic logic [31:0] crc8(logic [31:0] a, logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			a = (a << 1) ^ ((a[p] ^ b[i]) ? taps : 32'h0);
		return a & ~(32'hFFFFFFFE << p);
	endfunction : crc8
	task summarize;
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	task wr_reg(input logic [3:0] a, logic [31:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task rd_reg(input logic [3:0] a, logic [31:0] e);
		exp_q.push_back(e);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask : rd_reg
	// read data stands only in the cycle after the strobe
	always @(posedge clk)
	begin
		if (pend)
		begin
			checks++;
			if (rdata !== exp_q[0])
			begin
				n_fail++;
				$display("unexpected %0t %h %h", $time, rdata, exp_q[0]);
			end
			// the running view must agree with what an accumulator read shows
			if (pa == 4'h4 && csum !== exp_q[0])
			begin
				n_fail++;
				$display("unexpected %0t %h %h", $time, csum, exp_q[0]);
			end
			void'(exp_q.pop_front());
		end
		pend = rd;
		pa = addr;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 16; i += 4)
			rd_reg(i[3:0], 32'h0);
		taps = r;
		wr_reg(4'h8, taps);
		rd_reg(4'h8, taps);
		// narrow length with byte pairs, then full length single bytes
		for (int k = 0; k < 2; k++)
		begin
			p = k ? 5'd31 : 5'd7;
			wr_reg(4'h0, {19'h0, p, 7'h0, ~k[0]});
			r = nxt(r);
			acc = r & ~(32'hFFFFFFFE << p);
			wr_reg(4'h4, r);
			rd_reg(4'h4, acc);
			repeat (6)
			begin
				r = nxt(r);
				u_dcg_dma_model.send(r[15:0]);
				acc = crc8(acc, r[15:8]);
				acc = k ? acc : crc8(acc, r[7:0]);
			end
			rd_reg(4'h4, acc);
		end
		wr_reg(4'h0, 32'h00008000);
		r = nxt(r);
		wr_reg(4'h4, r);
		rd_reg(4'h4, {16'h0, r[15:0]});
		s = {1'b0, ~r[15:0]};
		repeat (6)
		begin
			r = nxt(r);
			u_dcg_dma_model.send(r[15:0]);
			s = s[15:0] + r[15:0];
			s = s[15:0] + s[16];
		end
		rd_reg(4'h4, {16'h0, ~s[15:0]});
		// let the watcher take the last answer before the verdict
		@(posedge clk);
		summarize();
	end
	initial
	begin
		repeat (1000) @(posedge clk);
		n_fail++;
		summarize();
	end
endmodule : dma_crc_generator_bench
